/* File: design/pwc_pkg.sv */
// package: register map, field layout, timing and state types for the pwm output stage
`default_nettype none
package pwc_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_TAG    = 8'h1b;
    localparam logic [7:0] IDX_CLAMP  = 8'h1c;
    localparam logic [7:0] IDX_CFG    = 8'h1e;
    localparam logic [7:0] IDX_STATUS = 8'h20;
    localparam logic [7:0] ADDR_TAG    = 8'h6c;
    localparam logic [7:0] ADDR_CLAMP  = 8'h70;
    localparam logic [7:0] ADDR_CFG    = 8'h78;
    localparam logic [7:0] ADDR_STATUS = 8'h80;
    // field positions
    localparam int TAG_LSB    = 12;
    localparam int HI_LSB     = 18;
    localparam int LO_LSB     = 12;
    localparam int CAL_BIT    = 3;
    localparam int CAR_LSB    = 0;
    localparam int ST_SMP_LSB = 0;
    localparam int ST_CAL_BIT = 12;
    localparam int ST_RES_LSB = 13;
    localparam int ST_PHI_BIT = 17;
    localparam int ST_PLO_BIT = 18;
    // reset values
    localparam logic [8:0] TAG_RST = 9'h000;
    localparam logic [5:0] HI_RST  = 6'h00;
    localparam logic [5:0] LO_RST  = 6'h00;
    localparam logic       CAL_RST = 1'b0;
    localparam logic [2:0] CAR_RST = 3'h0;
    // clamp geometry: 12-bit full scale, 64 steps over each half
    localparam logic [11:0] FS_MAX    = 12'hfff;
    localparam int          STEP_BITS = 5;
    // timing at 125 MHz
    localparam longint CLK_PERIOD_NS  = 64'd8;
    localparam longint CAL_TIME_MS    = 64'd800;
    localparam longint CAL_CYCLES_DEF = (CAL_TIME_MS * 64'd1000000) / CLK_PERIOD_NS;
    localparam longint BASE_PERIOD_NS = 64'd8000000; // 0.125 kHz carrier
    localparam longint BASE_CYCLES_DEF = BASE_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [2:0] CAR_FASTEST = 3'h5;

    typedef enum logic [1:0]
    {
        MODE_CAL = 2'b01,
        MODE_RUN = 2'b10
    } pwc_mode_e;

    typedef struct packed
    {
        logic [8:0] tag;
        logic [5:0] hi_code;
        logic [5:0] lo_code;
        logic       hi_prog;
        logic       lo_prog;
        logic       cal_en;
        logic [2:0] car;
    } pwc_cfg_s;
endpackage
`default_nettype wire

/* File: design/pwc_top.sv */
// pwm output stage: carrier select, output clamps, startup duty calibration, apb registers
//
// Functional notes
// - with calibration enabled, output exactly 50% duty for 800 ms after reset.
// - calibration enable resets to 0, meaning no calibration window.
// - clamps are the last processing step before the sample drives the output.
// - 6-bit upper code sets how much of the upper half passes.
// - upper code 0 gives the highest limit, 0x3f the lowest.
// - 6-bit lower code sets how much of the lower half passes.
// - lower code 0 gives the lowest limit, 0x3f the highest.
// - an unprogrammed clamp code falls back to the factory initial limit.
// - carrier codes 0..5 give 0.125..4 kHz; codes 6 and 7 give 0.125 kHz.
// - resolution is 12 bits up to 0.5 kHz, then 11, 10, 9 bits.
// - 9-bit customer tag is stored and read back only.
//
// Decided for this implementation: the APB slave port.
`default_nettype none
module pwc_top
#(
    parameter int unsigned CAL_CYCLES  = 32'(pwc_pkg::CAL_CYCLES_DEF),
    parameter int unsigned BASE_CYCLES = 32'(pwc_pkg::BASE_CYCLES_DEF),
    parameter logic [5:0]  HI_INIT     = 6'h00,
    parameter logic [5:0]  LO_INIT     = 6'h00
)
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // processed signal in
    input  wire logic [11:0] smp_data,
    input  wire logic        smp_valid,
    // output stage
    output logic             pwm_out,
    output logic             cal_active
);
    typedef struct packed
    {
        pwc_pkg::pwc_cfg_s  cfg;
        pwc_pkg::pwc_mode_e mode;
        logic [26:0]        cal_cnt;
        logic [11:0]        smp;
        logic [19:0]        cnt;
        logic [19:0]        per;
        logic [19:0]        duty;
        logic               pwm;
        logic               cal_act;
        logic [31:0]        rdata;
        logic               rdy;
        logic               err;
    } pwc_state_s;

    localparam logic [26:0] CAL_LAST = 27'(CAL_CYCLES - 32'd1);
    localparam logic [19:0] BASE_PER = 20'(BASE_CYCLES);

    pwc_state_s s_q;
    pwc_state_s s_d;

    logic [5:0]  hi_eff;
    logic [5:0]  lo_eff;
    logic [11:0] hi_lim;
    logic [11:0] lo_lim;
    logic [11:0] smp_clamped;
    logic [19:0] per_sel;
    logic [3:0]  res_sel;
    logic        wrap;
    logic        wr_acc;
    logic        setup;

    // codes 6 and 7 fall back to the slowest carrier
    function automatic logic [2:0] car_shift(input logic [2:0] car);
        car_shift = (car > pwc_pkg::CAR_FASTEST) ? 3'h0 : car;
    endfunction

    function automatic logic [3:0] car_res(input logic [2:0] car);
        case (car_shift(car))
            3'h3:    car_res = 4'hb;
            3'h4:    car_res = 4'ha;
            3'h5:    car_res = 4'h9;
            default: car_res = 4'hc;
        endcase
    endfunction

    // drop low bits beyond the resolution, then scale onto the period
    function automatic logic [19:0] duty_of(input logic [11:0] v, input logic [3:0] r, input logic [19:0] p);
        logic [11:0] q;
        logic [31:0] prod;
        q    = v >> (4'hc - r);
        prod = {20'h00000, q} * {12'h000, p};
        duty_of = 20'(prod >> r);
    endfunction

    always_comb
    begin
        s_d = s_q;
        // unprogrammed codes use the factory values
        hi_eff = s_q.cfg.hi_prog ? s_q.cfg.hi_code : HI_INIT;
        lo_eff = s_q.cfg.lo_prog ? s_q.cfg.lo_code : LO_INIT;
        hi_lim = pwc_pkg::FS_MAX - {1'b0, hi_eff, 5'h00};
        lo_lim = {1'b0, lo_eff, 5'h00};
        if (smp_data > hi_lim)
        begin
            smp_clamped = hi_lim;
        end
        else if (smp_data < lo_lim)
        begin
            smp_clamped = lo_lim;
        end
        else
        begin
            smp_clamped = smp_data;
        end
        per_sel = BASE_PER >> car_shift(s_q.cfg.car);
        res_sel = car_res(s_q.cfg.car);
        wrap    = (s_q.cnt >= s_q.per - 20'h1);
        setup   = psel && !penable;
        wr_acc  = psel && penable && pwrite && s_q.rdy;

        if (smp_valid)
        begin
            s_d.smp = smp_clamped;
        end

        // startup window runs for a fixed time from reset release
        // enable only gates the half duty, so a late enable never stretches the window
        case (s_q.mode)
            pwc_pkg::MODE_CAL:
            begin
                if (s_q.cal_cnt == CAL_LAST)
                begin
                    s_d.mode = pwc_pkg::MODE_RUN;
                end
                s_d.cal_cnt = s_q.cal_cnt + 27'h1;
            end
            pwc_pkg::MODE_RUN:
            begin
                s_d.cal_cnt = s_q.cal_cnt;
            end
            default:
            begin
                s_d.mode = pwc_pkg::MODE_RUN;
            end
        endcase
        s_d.cal_act = (s_d.mode == pwc_pkg::MODE_CAL) && s_q.cfg.cal_en;

        // period and duty change only at a carrier boundary, so no runt pulses
        if (wrap)
        begin
            s_d.cnt = 20'h0;
            s_d.per = per_sel;
            if (s_d.cal_act)
            begin
                s_d.duty = per_sel >> 1;
            end
            else
            begin
                s_d.duty = duty_of(s_q.smp, res_sel, per_sel);
            end
        end
        else
        begin
            s_d.cnt = s_q.cnt + 20'h1;
        end
        s_d.pwm = (s_d.cnt < s_d.duty);

        // apb: answer registered in setup, access completes with no wait
        s_d.rdy   = setup;
        s_d.err   = 1'b0;
        s_d.rdata = 32'h0;
        if (setup)
        begin
            if (paddr == pwc_pkg::ADDR_TAG)
            begin
                s_d.rdata[pwc_pkg::TAG_LSB +: 9] = s_q.cfg.tag;
            end
            else if (paddr == pwc_pkg::ADDR_CLAMP)
            begin
                s_d.rdata[pwc_pkg::HI_LSB +: 6] = s_q.cfg.hi_code;
                s_d.rdata[pwc_pkg::LO_LSB +: 6] = s_q.cfg.lo_code;
            end
            else if (paddr == pwc_pkg::ADDR_CFG)
            begin
                s_d.rdata[pwc_pkg::CAL_BIT]     = s_q.cfg.cal_en;
                s_d.rdata[pwc_pkg::CAR_LSB +: 3] = s_q.cfg.car;
            end
            else if (paddr == pwc_pkg::ADDR_STATUS)
            begin
                s_d.rdata[pwc_pkg::ST_SMP_LSB +: 12] = s_q.smp;
                s_d.rdata[pwc_pkg::ST_CAL_BIT]       = s_q.cal_act;
                s_d.rdata[pwc_pkg::ST_RES_LSB +: 4]  = res_sel;
                s_d.rdata[pwc_pkg::ST_PHI_BIT]       = s_q.cfg.hi_prog;
                s_d.rdata[pwc_pkg::ST_PLO_BIT]       = s_q.cfg.lo_prog;
            end
            else
            begin
                s_d.err = 1'b1;
            end
        end
        if (wr_acc)
        begin
            if (paddr == pwc_pkg::ADDR_TAG)
            begin
                s_d.cfg.tag = pwdata[pwc_pkg::TAG_LSB +: 9];
            end
            else if (paddr == pwc_pkg::ADDR_CLAMP)
            begin
                s_d.cfg.hi_code = pwdata[pwc_pkg::HI_LSB +: 6];
                s_d.cfg.lo_code = pwdata[pwc_pkg::LO_LSB +: 6];
                s_d.cfg.hi_prog = 1'b1;
                s_d.cfg.lo_prog = 1'b1;
            end
            else if (paddr == pwc_pkg::ADDR_CFG)
            begin
                s_d.cfg.cal_en = pwdata[pwc_pkg::CAL_BIT];
                s_d.cfg.car    = pwdata[pwc_pkg::CAR_LSB +: 3];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q.cfg.tag     <= pwc_pkg::TAG_RST;
            s_q.cfg.hi_code <= pwc_pkg::HI_RST;
            s_q.cfg.lo_code <= pwc_pkg::LO_RST;
            s_q.cfg.hi_prog <= 1'b0;
            s_q.cfg.lo_prog <= 1'b0;
            s_q.cfg.cal_en  <= pwc_pkg::CAL_RST;
            s_q.cfg.car     <= pwc_pkg::CAR_RST;
            s_q.mode        <= pwc_pkg::MODE_CAL;
            s_q.cal_cnt     <= 27'h0;
            s_q.smp         <= 12'h0;
            s_q.cnt         <= 20'h0;
            s_q.per         <= 20'h1;
            s_q.duty        <= 20'h0;
            s_q.pwm         <= 1'b0;
            s_q.cal_act     <= 1'b0;
            s_q.rdata       <= 32'h0;
            s_q.rdy         <= 1'b0;
            s_q.err         <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata     = s_q.rdata;
    assign pready     = s_q.rdy;
    assign pslverr    = s_q.err;
    assign pwm_out    = s_q.pwm;
    assign cal_active = s_q.cal_act;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // checks on the state that the outputs come from
    cal_half_duty_a: assert property (s_d.cal_act && wrap |=> s_q.duty == (s_q.per >> 1))
        else $error("calibration duty is not half the period");
    cal_off_exit_a: assert property (!s_q.cfg.cal_en |=> !s_q.cal_act)
        else $error("disabled calibration window still active");
    cal_window_end_a: assert property (s_q.mode == pwc_pkg::MODE_CAL && s_q.cal_cnt == CAL_LAST
        |=> s_q.mode == pwc_pkg::MODE_RUN && !s_q.cal_act)
        else $error("calibration window did not close on time");
    clamp_pass_a: assert property (smp_valid && smp_data <= hi_lim && smp_data >= lo_lim
        |=> s_q.smp == $past(smp_data))
        else $error("in-range sample was altered by the clamps");
    hi_above_lo_a: assert property (hi_lim > lo_lim)
        else $error("upper limit is not above lower limit");
    factory_low_a: assert property (!s_q.cfg.lo_prog |-> lo_lim == {1'b0, LO_INIT, 5'h00})
        else $error("unprogrammed lower clamp ignores factory value");
    carrier_slow_a: assert property (s_q.cfg.car > pwc_pkg::CAR_FASTEST
        |-> per_sel == BASE_PER && res_sel == 4'hc)
        else $error("codes 6 and 7 do not select the slowest carrier");
    res_mid_a: assert property (s_q.cfg.car == 3'h3 |-> res_sel == 4'hb)
        else $error("1 kHz carrier resolution is not 11 bits");
    pwm_off_zero_a: assert property (s_q.duty == 20'h0 |-> !s_q.pwm)
        else $error("pwm output high with zero duty");
    cal_window_len_a: assert property (s_q.cal_act |-> s_q.cal_cnt <= CAL_LAST)
        else $error("calibration window overran its length");
    clamp_bounds_a: assert property (smp_valid |=> s_q.smp <= $past(hi_lim) && s_q.smp >= $past(lo_lim))
        else $error("clamped sample outside limits");
    upper_code_a: assert property (s_q.cfg.hi_prog && s_q.cfg.hi_code == 6'h3f |-> hi_lim == 12'h81f)
        else $error("upper code 0x3f gives wrong limit");
    lower_code_a: assert property (s_q.cfg.lo_prog && s_q.cfg.lo_code == 6'h3f |-> lo_lim == 12'h7e0)
        else $error("lower code 0x3f gives wrong limit");
    factory_clamp_a: assert property (!s_q.cfg.hi_prog |-> hi_lim == pwc_pkg::FS_MAX - {1'b0, HI_INIT, 5'h00})
        else $error("unprogrammed upper clamp ignores factory value");
    carrier_sel_a: assert property (wrap |=> s_q.per == (BASE_PER >> car_shift($past(s_q.cfg.car))))
        else $error("carrier period does not follow the code");
    res_fastest_a: assert property (s_q.cfg.car == 3'h5 |-> res_sel == 4'h9)
        else $error("fastest carrier resolution is not 9 bits");
    pwm_follow_a: assert property (##1 s_q.pwm == (s_q.cnt < s_q.duty))
        else $error("pwm output does not follow the duty count");
endmodule
`default_nettype wire

/* File: tb/pwc_meter.sv */
// controller model: measures carrier period and on time of pwm_out
`default_nettype none
module pwc_meter
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // measured line
    input  wire logic        pwm_out,
    // last whole period and on time, in clocks
    output logic      [15:0] per_q,
    output logic      [15:0] hi_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt_q;
    logic [15:0] hcnt_q;
    logic        last_q;
    // each rising edge is the reference point of a period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            per_q  <= 16'h0000;
            hi_q   <= 16'h0000;
            cnt_q  <= 16'h0000;
            hcnt_q <= 16'h0000;
            last_q <= 1'b0;
        end
        else
        begin
            last_q <= pwm_out;
            if (pwm_out && !last_q)
            begin
                per_q  <= cnt_q;
                hi_q   <= hcnt_q;
                cnt_q  <= 16'h0001;
                hcnt_q <= 16'h0001;
            end
            else
            begin
                cnt_q  <= cnt_q + 16'h0001;
                hcnt_q <= hcnt_q + 16'(pwm_out);
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/pwc_top_test.sv */
// self-checking bench for the pwm output stage
`default_nettype none
module pwc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BASE = 64;
    localparam logic [5:0] HI_F = 6'h04;
    localparam logic [5:0] LO_F = 6'h02;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [11:0] smp_data = 12'h000;
    logic        smp_valid = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pwm_out;
    logic        cal_active;
    logic [15:0] meas_per;
    logic [15:0] meas_hi;
    logic [31:0] rd;
    logic        err;
    int          errors = 0;
    int          samples_checked = 0;
    always #4 pclk = ~pclk;
    // short counts keep the run brief
    pwc_top #(.CAL_CYCLES(200), .BASE_CYCLES(BASE), .HI_INIT(HI_F), .LO_INIT(LO_F)) pwc_top_inst (
        .pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .smp_data(smp_data),
        .smp_valid(smp_valid), .pwm_out(pwm_out), .cal_active(cal_active));
    pwc_meter pwc_meter_inst (.pclk(pclk), .presetn(presetn), .pwm_out(pwm_out),
        .per_q(meas_per), .hi_q(meas_hi));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    // request held until pready is seen high at a rising edge, released at that same edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n >= 50)
            chk("pready", 32'h1, 32'(pready));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic smp(input logic [11:0] d, input logic [11:0] exp);
        @(posedge pclk);
        smp_data <= d;
        smp_valid <= 1'b1;
        @(posedge pclk);
        smp_valid <= 1'b0;
        repeat (2) @(posedge pclk);
        apb(pwc_pkg::ADDR_STATUS, 1'b0, 32'h0);
        chk("clamped", 32'(exp), 32'(rd[11:0]));
    endtask
    task automatic t_reset();
        chk("cal_active", 32'h0, 32'(cal_active));
        apb(pwc_pkg::ADDR_CFG, 1'b0, 32'h0);
        chk("cfg rst", 32'h0, rd);
        apb(pwc_pkg::ADDR_CLAMP, 1'b0, 32'h0);
        chk("clamp rst", 32'h0, rd);
        apb(pwc_pkg::ADDR_TAG, 1'b0, 32'h0);
        chk("tag rst", 32'h0, rd);
        apb(8'h04, 1'b0, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
        apb(pwc_pkg::ADDR_STATUS, 1'b0, 32'h0);
        chk("prog flags", 32'h0, 32'(rd[18:17]));
    endtask
    // enable written inside the startup window, which must still close on time
    task automatic t_cal();
        apb(pwc_pkg::ADDR_CFG, 1'b1, 32'h1 << pwc_pkg::CAL_BIT);
        repeat (2) @(posedge pclk);
        chk("cal_active on", 32'h1, 32'(cal_active));
        repeat (2 * BASE) @(posedge pclk);
        chk("cal period", 32'(BASE), 32'(meas_per));
        chk("cal half duty", 32'(BASE / 2), 32'(meas_hi));
        repeat (2 * BASE) @(posedge pclk);
        chk("cal_active off", 32'h0, 32'(cal_active));
    endtask
    task automatic t_tag();
        apb(pwc_pkg::ADDR_TAG, 1'b1, 32'h0015a000);
        apb(pwc_pkg::ADDR_TAG, 1'b0, 32'h0);
        chk("tag", 32'h0015a000, rd);
    endtask
    task automatic t_clamp();
        logic [11:0] lo;
        lo = 12'(6'h3f) << pwc_pkg::STEP_BITS;
        smp(12'hfff, pwc_pkg::FS_MAX - (12'(HI_F) << pwc_pkg::STEP_BITS));
        smp(12'h000, 12'(LO_F) << pwc_pkg::STEP_BITS);
        apb(pwc_pkg::ADDR_CLAMP, 1'b1, (32'h3f << pwc_pkg::HI_LSB) | (32'h3f << pwc_pkg::LO_LSB));
        apb(pwc_pkg::ADDR_STATUS, 1'b0, 32'h0);
        chk("prog flags", 32'h3, 32'(rd[18:17]));
        smp(12'hfff, pwc_pkg::FS_MAX - lo);
        smp(12'h000, lo);
        repeat (4 * BASE) @(posedge pclk);
        chk("on time", (32'(lo) * BASE) >> 12, 32'(meas_hi));
        apb(pwc_pkg::ADDR_CLAMP, 1'b1, (32'h1 << pwc_pkg::HI_LSB) | (32'h1 << pwc_pkg::LO_LSB));
        smp(12'hfff, pwc_pkg::FS_MAX - 12'h020);
        smp(12'h001, 12'h020);
    endtask
    task automatic t_carrier();
        int res;
        int per;
        smp(12'h800, 12'h800);
        for (int c = 0; c < 8; c++)
        begin
            res = (c == 3) ? 11 : (c == 4) ? 10 : (c == 5) ? 9 : 12;
            per = (c > 5) ? BASE : (BASE >> c);
            apb(pwc_pkg::ADDR_CFG, 1'b1, 32'(c));
            repeat (4 * BASE) @(posedge pclk);
            apb(pwc_pkg::ADDR_STATUS, 1'b0, 32'h0);
            chk("resolution", 32'(res), 32'(rd[16:13]));
            chk("period", 32'(per), 32'(meas_per));
            chk("half duty", 32'(per / 2), 32'(meas_hi));
        end
        // startup window ended long ago and enable is now clear
        chk("cal_active", 32'h0, 32'(cal_active));
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #(8 * 20000);
        errors++;
        conclude();
    end
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_cal();
        t_tag();
        t_clamp();
        t_carrier();
        conclude();
    end
endmodule
`default_nettype wire
